/* verilog/drt_map.svh */
// constants of the delay relay timing controller
`ifndef DRT_MAP_SVH
`define DRT_MAP_SVH

// timebase: clock period and the 1 ms tick derived from it
`define DRT_CLK_NS        25
`define DRT_TICK_NS       1000000
`define DRT_TICK_CYCLES   (`DRT_TICK_NS / `DRT_CLK_NS)

// full scale of each decade range in ms, selector code 0 to 7
`define DRT_RANGE0_MS     26'd1000
`define DRT_RANGE1_MS     26'd10000
`define DRT_RANGE2_MS     26'd100000
`define DRT_RANGE3_MS     26'd60000
`define DRT_RANGE4_MS     26'd600000
`define DRT_RANGE5_MS     26'd6000000
`define DRT_RANGE6_MS     26'd3600000
`define DRT_RANGE7_MS     26'd36000000

// fine adjust fraction is fine_adj / 2**shift
`define DRT_FINE_SHIFT    8
`define DRT_MIN_DELAY_MS  26'd1

// half period of the output indicator blink, in ms
`define DRT_BLINK_MS      8'd250

// reset values
`define DRT_RELAY_RST     1'b0
`define DRT_LED_RST       1'b0
`define DRT_BLINK_RST     1'b1

`endif

/* verilog/drt_pkg.sv */
// types of the delay relay timing controller
package drt_pkg;
    typedef logic [2:0]  drt_range_t;
    typedef logic [7:0]  drt_fine_t;
    typedef logic [1:0]  drt_aux_t;
    typedef logic [25:0] drt_ms_t;

    typedef enum logic [2:0] {
        DRT_ON_DELAY,
        DRT_INTERVAL,
        DRT_OFF_DELAY,
        DRT_ONE_SHOT,
        DRT_ONOFF_DELAY,
        DRT_LATCH
    } drt_mode_t;

    // idle: off; wait: off and timing; on: energized; hold: on and timing
    typedef enum logic [1:0] {
        DRT_ST_IDLE,
        DRT_ST_WAIT,
        DRT_ST_ON,
        DRT_ST_HOLD
    } drt_state_t;
endpackage : drt_pkg

/* verilog/drt_tick.sv */
// free-running millisecond timebase
`timescale 1ns/1ps
`default_nettype none
module drt_tick #(
    parameter int unsigned CYCLES = 40000
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // one-cycle pulse every CYCLES clocks
    output var  logic tick_q
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] div_q;

    // divider never stops, so a delay may end up to one tick short
    always_ff @(posedge clk_sys) begin
        if (!nrst || div_q == W'(CYCLES - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == W'(CYCLES - 1));
        end
    end
endmodule : drt_tick
`default_nettype wire

/* verilog/drt_ctrl.sv */
// delay relay timing controller: modes, delay timer, relay and indicators
//
// Overview of operation
// - on/off delay: trigger closing starts timing
// - on/off delay: relay on at timeout until open
// - memory latch: relay toggles on each closure
// - power loss drops relay and all state
// - three selector bits pick eight decades, ascending within the seconds, minutes and hours groups
// - delay equals range times fine fraction, but never less than 1 ms
// - power indicator lit while power present
// - output indicator blinks timing, steady when energized and not timing
// - first build: select off on-delay, on interval
// - second build: select off off-delay, on one-shot
// - on delay: timing from power, trigger ignored
// - interval: relay on at power, off at timeout
// - off delay: close energizes, open times, reclose restarts
// - one shot: each closure restarts, release at timeout
`timescale 1ns/1ps
`default_nettype none
`include "drt_map.svh"
module drt_ctrl #(
    parameter int unsigned TICK_CYCLES = `DRT_TICK_CYCLES
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // supply and trigger, synchronous levels
    input  wire logic              pwr_present,
    input  wire logic              trig_closed,
    // setting switches
    input  wire logic              variant_b,
    input  wire logic              fn_sel,
    input  wire drt_pkg::drt_aux_t aux_fn,
    input  wire drt_pkg::drt_range_t range_sel,
    input  wire drt_pkg::drt_fine_t  fine_adj,
    // relay and indicators
    output var  logic              relay_out_q,
    output var  logic              timing_q,
    output var  logic              pwr_led_q,
    output var  logic              out_led_q
);
    import drt_pkg::*;

    drt_mode_t  mode;
    drt_state_t st_q;
    drt_state_t st_d;
    drt_ms_t    tgt_ms;
    drt_ms_t    cnt_q;
    logic [7:0] blink_cnt_q;
    logic       blink_q;
    logic       pwr_q;
    logic       trig_q;
    logic       ms_tick;
    logic       restart;
    logic       timeout;
    logic       pwr_rise;
    logic       trig_rise;
    logic       trig_fall;

    function automatic logic is_timing(input drt_state_t s);
        return (s == DRT_ST_WAIT) || (s == DRT_ST_HOLD);
    endfunction : is_timing

    function automatic logic is_relay(input drt_state_t s);
        return (s == DRT_ST_ON) || (s == DRT_ST_HOLD);
    endfunction : is_relay

    // decade full scale, ascending with the selector code within seconds (0-2), minutes (3-5) and hours (6-7)
    function automatic drt_ms_t range_ms(input drt_range_t sel);
        drt_ms_t r;
        r = `DRT_RANGE0_MS;
        if (sel == 3'h1) r = `DRT_RANGE1_MS;
        else if (sel == 3'h2) r = `DRT_RANGE2_MS;
        else if (sel == 3'h3) r = `DRT_RANGE3_MS;
        else if (sel == 3'h4) r = `DRT_RANGE4_MS;
        else if (sel == 3'h5) r = `DRT_RANGE5_MS;
        else if (sel == 3'h6) r = `DRT_RANGE6_MS;
        else if (sel == 3'h7) r = `DRT_RANGE7_MS;
        return r;
    endfunction : range_ms

    // aux 01 and 10 reach the trigger modes outside the two builds
    always_comb begin
        if (aux_fn == 2'h1) mode = DRT_ONOFF_DELAY;
        else if (aux_fn == 2'h2) mode = DRT_LATCH;
        else if (variant_b) mode = fn_sel ? DRT_ONE_SHOT : DRT_OFF_DELAY;
        else mode = fn_sel ? DRT_INTERVAL : DRT_ON_DELAY;
    end

    // settings are live, so turning the knob stretches or shortens a running delay
    always_comb begin
        logic [33:0] prod;
        prod = {8'h00, range_ms(range_sel)} * {26'h0, fine_adj};
        tgt_ms = prod[33:`DRT_FINE_SHIFT];
        if (tgt_ms < `DRT_MIN_DELAY_MS) tgt_ms = `DRT_MIN_DELAY_MS;
    end

    drt_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .tick_q  (ms_tick)
    );

    assign pwr_rise  = pwr_present && !pwr_q;
    assign trig_rise = trig_closed && !trig_q;
    assign trig_fall = !trig_closed && trig_q;
    assign timeout   = is_timing(st_q) && ms_tick
                       && ((cnt_q + 26'd1) >= tgt_ms);

    // edge history of supply and trigger
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pwr_q  <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            pwr_q  <= pwr_present;
            trig_q <= trig_closed;
        end
    end

    // function sequencer
    always_comb begin
        st_d    = st_q;
        restart = 1'b0;
        if (!pwr_present) begin
            st_d = DRT_ST_IDLE;
        end else begin
            case (mode)
                DRT_ON_DELAY: begin
                    if (pwr_rise) begin
                        st_d    = DRT_ST_WAIT;
                        restart = 1'b1;
                    end else if (st_q == DRT_ST_WAIT && timeout) begin
                        st_d = DRT_ST_ON;
                    end
                end
                DRT_INTERVAL: begin
                    if (pwr_rise) begin
                        st_d    = DRT_ST_HOLD;
                        restart = 1'b1;
                    end else if (st_q == DRT_ST_HOLD && timeout) begin
                        st_d = DRT_ST_IDLE;
                    end
                end
                DRT_OFF_DELAY: begin
                    if (trig_rise) begin
                        st_d = DRT_ST_ON;
                    end else if (trig_fall && st_q != DRT_ST_IDLE) begin
                        st_d    = DRT_ST_HOLD;
                        restart = 1'b1;
                    end else if (st_q == DRT_ST_HOLD && timeout) begin
                        st_d = DRT_ST_IDLE;
                    end
                end
                DRT_ONE_SHOT: begin
                    if (trig_rise) begin
                        st_d    = DRT_ST_HOLD;
                        restart = 1'b1;
                    end else if (st_q == DRT_ST_HOLD && timeout) begin
                        st_d = DRT_ST_IDLE;
                    end
                end
                DRT_ONOFF_DELAY: begin
                    if (trig_rise) begin
                        st_d    = DRT_ST_WAIT;
                        restart = 1'b1;
                    end else if (!trig_closed) begin
                        st_d = DRT_ST_IDLE;
                    end else if (st_q == DRT_ST_WAIT && timeout) begin
                        st_d = DRT_ST_ON;
                    end
                end
                DRT_LATCH: begin
                    if (trig_rise) begin
                        st_d = is_relay(st_q) ? DRT_ST_IDLE : DRT_ST_ON;
                    end else if (is_timing(st_q)) begin
                        st_d = DRT_ST_IDLE;
                    end
                end
                default: st_d = DRT_ST_IDLE;
            endcase
        end
    end

    // state and registered outputs share one next value
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_q        <= DRT_ST_IDLE;
            relay_out_q <= `DRT_RELAY_RST;
            timing_q    <= 1'b0;
        end else begin
            st_q        <= st_d;
            relay_out_q <= is_relay(st_d);
            timing_q    <= is_timing(st_d);
        end
    end

    // elapsed ms of the running delay
    always_ff @(posedge clk_sys) begin
        if (!nrst || restart || !is_timing(st_d)) begin
            cnt_q <= '0;
        end else if (ms_tick) begin
            cnt_q <= cnt_q + 26'd1;
        end
    end

    // blink phase, starts lit so a short delay still shows; it restarts
    // with the delay counter so a tick on the start edge cannot shorten
    // the first lit half period
    always_ff @(posedge clk_sys) begin
        if (!nrst || restart || !is_timing(st_d)) begin
            blink_cnt_q <= 8'h00;
            blink_q     <= `DRT_BLINK_RST;
        end else if (ms_tick) begin
            if (blink_cnt_q == `DRT_BLINK_MS - 8'd1) begin
                blink_cnt_q <= 8'h00;
                blink_q     <= !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 8'd1;
            end
        end
    end

    // indicators; timing wins over steady so a held relay still blinks
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pwr_led_q <= `DRT_LED_RST;
            out_led_q <= `DRT_LED_RST;
        end else begin
            pwr_led_q <= pwr_present;
            out_led_q <= is_timing(st_d) ? blink_q : is_relay(st_d);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    onoff_start_a: assert property (mode == DRT_ONOFF_DELAY && pwr_present
        && trig_rise |=> timing_q && !relay_out_q && cnt_q == 26'd0)
        else $error("on/off delay did not start timing");
    onoff_fire_a: assert property (mode == DRT_ONOFF_DELAY && pwr_present
        && trig_closed && st_q == DRT_ST_WAIT && timeout
        |=> relay_out_q && !timing_q)
        else $error("on/off delay did not energize at timeout");
    onoff_abort_a: assert property (mode == DRT_ONOFF_DELAY
        && !trig_closed |=> !relay_out_q && !timing_q)
        else $error("on/off delay kept output with trigger open");
    latch_toggle_a: assert property (mode == DRT_LATCH && pwr_present
        && trig_rise |=> relay_out_q != $past(relay_out_q))
        else $error("latch did not toggle");
    pwr_loss_a: assert property (!pwr_present
        |=> !relay_out_q && !timing_q && st_q == DRT_ST_IDLE)
        else $error("state kept without power");
    range_scale_a: assert property (range_sel == 3'h7
        && fine_adj == 8'h80 |-> tgt_ms == 26'd18000000)
        else $error("range or fine scaling wrong");
    fine_min_a: assert property (range_sel == 3'h0 && fine_adj == 8'h40
        |-> tgt_ms == 26'd250)
        else $error("fine fraction wrong");
    pwr_led_a: assert property (pwr_present |=> pwr_led_q)
        else $error("power indicator dark with power");
    led_steady_a: assert property (relay_out_q && !timing_q
        |-> out_led_q)
        else $error("output indicator not steady");
    led_dark_a: assert property (!relay_out_q && !timing_q
        |-> !out_led_q)
        else $error("output indicator lit while idle");
    build_mode_a: assert property (aux_fn == 2'h0 |-> mode ==
        (variant_b ? (fn_sel ? DRT_ONE_SHOT : DRT_OFF_DELAY)
                   : (fn_sel ? DRT_INTERVAL : DRT_ON_DELAY)))
        else $error("function select decode wrong");
    on_delay_a: assert property (mode == DRT_ON_DELAY && pwr_rise
        |=> timing_q && !relay_out_q)
        else $error("on delay did not start at power");
    interval_a: assert property (mode == DRT_INTERVAL && pwr_rise
        |=> relay_out_q && timing_q)
        else $error("interval did not energize at power");
    off_delay_a: assert property (mode == DRT_OFF_DELAY && pwr_present
        && trig_rise |=> relay_out_q && !timing_q)
        else $error("off delay did not energize on closure");
    one_shot_a: assert property (mode == DRT_ONE_SHOT && pwr_present
        && trig_rise |=> relay_out_q && timing_q && cnt_q == 26'd0)
        else $error("one shot did not restart");
    expiry_a: assert property (timeout && pwr_present && !trig_rise
        && mode != DRT_LATCH |=> !timing_q)
        else $error("timer ran past its target");

    on_delay_c: cover property (mode == DRT_ON_DELAY && timeout);
    off_delay_c: cover property (mode == DRT_OFF_DELAY && timeout);
    retrig_c: cover property (mode == DRT_ONE_SHOT
        && st_q == DRT_ST_HOLD && trig_rise);
    latch_c: cover property (mode == DRT_LATCH && relay_out_q && trig_rise);
endmodule : drt_ctrl
`default_nettype wire

/* dv/drt_farside.sv */
// far side model: input supply, trigger switch and switched load
`timescale 1ns/1ps
`default_nettype none
module drt_farside (
    // clock
    input  wire logic clk_sys,
    // commands from the bench
    input  wire logic pwr_cmd,
    input  wire logic trig_cmd,
    // relay contact from the device
    input  wire logic relay_out_q,
    // supply, trigger and load
    output var  logic pwr_present,
    output var  logic trig_closed,
    output var  logic load_on
);
    // contacts settle on a clock edge, as a synchronised switch would
    always_ff @(posedge clk_sys) begin
        pwr_present <= pwr_cmd;
        trig_closed <= trig_cmd;
    end
    // load only runs while the contact is closed and the supply is there
    assign load_on = relay_out_q & pwr_present;
endmodule : drt_farside
`default_nettype wire

/* dv/drt_ctrl_test.sv */
// self-checking bench of the delay relay timing controller
`timescale 1ns/1ps
`default_nettype none
`include "drt_map.svh"
module drt_ctrl_test;
    import drt_pkg::*;
    localparam int TK = 4; // short ms tick keeps each ms only 4 clocks long
    logic       clk_sys   = 1'b0;
    logic       nrst      = 1'b0;
    logic       pwr_cmd   = 1'b0;
    logic       trig_cmd  = 1'b0;
    logic       variant_b = 1'b0;
    logic       fn_sel    = 1'b0;
    drt_aux_t   aux_fn    = 2'h0;
    drt_range_t range_sel = 3'h0;
    drt_fine_t  fine_adj  = 8'h04;
    logic       pwr_present, trig_closed, load_on;
    logic       relay_out_q, timing_q, pwr_led_q, out_led_q;
    logic       blink;
    int         err_total = 0;
    int         n_checks  = 0;
    int         now       = 0;
    int         t0;
    drt_ms_t    full [5]  = '{`DRT_RANGE0_MS, `DRT_RANGE1_MS,
                              `DRT_RANGE2_MS, `DRT_RANGE3_MS, `DRT_RANGE4_MS};

    drt_farside drt_farside_i (.clk_sys(clk_sys), .pwr_cmd(pwr_cmd),
        .trig_cmd(trig_cmd), .relay_out_q(relay_out_q),
        .pwr_present(pwr_present), .trig_closed(trig_closed),
        .load_on(load_on));
    drt_ctrl #(.TICK_CYCLES(TK)) drt_ctrl_i (.clk_sys(clk_sys), .nrst(nrst),
        .pwr_present(pwr_present), .trig_closed(trig_closed),
        .variant_b(variant_b), .fn_sel(fn_sel), .aux_fn(aux_fn),
        .range_sel(range_sel), .fine_adj(fine_adj),
        .relay_out_q(relay_out_q), .timing_q(timing_q),
        .pwr_led_q(pwr_led_q), .out_led_q(out_led_q));

    // 40 MHz clock and a free cycle count for delay measurement
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) now <= now + 1;

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task check(input logic seen, input logic exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check

    // two edges of input latency plus up to one tick of timebase jitter;
    // a tight window lets a missed restart show as a short delay
    task check_dt(input int t_ms, input string msg);
        int dt;
        dt = now - t0;
        check(dt >= (t_ms - 1) * TK + 3 && dt <= t_ms * TK + 2, 1'b1, msg);
    endtask : check_dt

    // commands change at a rising edge, outputs are read settled
    task drive(input logic p, input logic t);
        @(posedge clk_sys);
        pwr_cmd  <= p;
        trig_cmd <= t;
        repeat (4) @(negedge clk_sys);
    endtask : drive

    task setup(input logic vb, input logic fs, input drt_aux_t ax,
               input drt_range_t r, input drt_fine_t f);
        @(posedge clk_sys);
        variant_b <= vb;
        fn_sel    <= fs;
        aux_fn    <= ax;
        range_sel <= r;
        fine_adj  <= f;
        drive(1'b0, 1'b0);
    endtask : setup

    // bounded wait for the running delay to end, noting any dark indicator
    task wait_end;
        int n;
        n = 0;
        blink = 1'b0;
        while (timing_q === 1'b1 && n < 40000) begin
            if (out_led_q === 1'b0) blink = 1'b1;
            @(negedge clk_sys);
            n++;
        end
        if (n >= 40000) begin
            err_total++;
            $display("[FAIL] %0t delay never ended", $time);
            summarize();
        end
    endtask : wait_end

    task t_on_delay;
        setup(1'b0, 1'b0, 2'h0, 3'h0, 8'h04); // 15 ms
        check(pwr_led_q, 1'b0, "power led lit without power");
        drive(1'b1, 1'b0);
        t0 = now - 3;
        check(pwr_led_q, 1'b1, "power led dark");
        check(timing_q, 1'b1, "on delay not timing");
        check(out_led_q, 1'b1, "out led dark at start");
        drive(1'b1, 1'b1);
        check(relay_out_q, 1'b0, "on delay trigger acted");
        wait_end();
        check_dt(15, "on delay length");
        check(relay_out_q, 1'b1, "on delay relay off");
        check(out_led_q, 1'b1, "out led not steady");
        drive(1'b0, 1'b1);
        check(relay_out_q, 1'b0, "relay kept after power loss");
        $display("test on_delay done");
    endtask : t_on_delay

    task t_interval;
        setup(1'b0, 1'b1, 2'h3, 3'h0, 8'h04);
        drive(1'b1, 1'b0);
        t0 = now - 3;
        check(relay_out_q, 1'b1, "interval relay off");
        check(timing_q, 1'b1, "interval not timing");
        wait_end();
        check_dt(15, "interval length");
        check(relay_out_q, 1'b0, "interval relay stays");
        drive(1'b1, 1'b1);
        check(relay_out_q, 1'b0, "interval trigger acted");
        $display("test interval done");
    endtask : t_interval

    task t_off_delay;
        setup(1'b1, 1'b0, 2'h0, 3'h0, 8'h04);
        drive(1'b1, 1'b0);
        check(relay_out_q | timing_q, 1'b0, "off delay active idle");
        drive(1'b1, 1'b1);
        check(relay_out_q, 1'b1, "off delay close no relay");
        check(timing_q, 1'b0, "off delay timing closed");
        drive(1'b1, 1'b0);
        check(timing_q, 1'b1, "off delay open no timing");
        drive(1'b1, 1'b1);
        check(timing_q, 1'b0, "reclose kept timing");
        check(relay_out_q, 1'b1, "reclose dropped relay");
        drive(1'b1, 1'b0);
        t0 = now - 3;
        wait_end();
        check_dt(15, "off delay length");
        check(relay_out_q, 1'b0, "off delay relay stays");
        $display("test off_delay done");
    endtask : t_off_delay

    task t_one_shot;
        setup(1'b1, 1'b1, 2'h0, 3'h0, 8'h04);
        drive(1'b1, 1'b1);
        check(relay_out_q & timing_q, 1'b1, "one shot not started");
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
        t0 = now - 3;
        wait_end();
        check_dt(15, "one shot not restarted");
        check(relay_out_q, 1'b0, "one shot relay stays");
        $display("test one_shot done");
    endtask : t_one_shot

    task t_on_off;
        setup(1'b0, 1'b0, 2'h1, 3'h0, 8'h04);
        drive(1'b1, 1'b1);
        check(timing_q, 1'b1, "closure did not time");
        check(relay_out_q, 1'b0, "relay early");
        drive(1'b1, 1'b0);
        check(timing_q | relay_out_q, 1'b0, "early open kept timing");
        drive(1'b1, 1'b1);
        t0 = now - 3;
        wait_end();
        check_dt(15, "on off delay length");
        check(relay_out_q, 1'b1, "relay off at timeout");
        drive(1'b1, 1'b0);
        check(relay_out_q, 1'b0, "relay kept after open");
        $display("test on_off done");
    endtask : t_on_off

    task t_latch;
        setup(1'b0, 1'b0, 2'h2, 3'h0, 8'h04);
        drive(1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            drive(1'b1, 1'b1);
            check(relay_out_q, i[0] == 1'b0, "latch no toggle");
            drive(1'b1, 1'b0);
            check(load_on, i[0] == 1'b0, "latch lost on open");
        end
        drive(1'b1, 1'b1);
        drive(1'b0, 1'b1);
        check(relay_out_q, 1'b0, "latch kept after power loss");
        $display("test latch done");
    endtask : t_latch

    // decade ranges and fine fractions measured in on delay mode
    task t_ranges;
        int tm;
        drt_range_t rs [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0,
                               3'h0};
        drt_fine_t  fs [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00,
                               8'hFF, 8'h40};
        // long decades: too slow to run out, so only checked as still timing
        drt_range_t lr [3] = '{3'h5, 3'h6, 3'h7};
        drt_fine_t  lf [3] = '{8'h01, 8'h01, 8'h80};
        for (int k = 0; k < 8; k++) begin
            tm = int'((full[rs[k]] * fs[k]) >> 8);
            if (tm < 1) tm = 1;
            setup(1'b0, 1'b0, 2'h0, rs[k], fs[k]);
            drive(1'b1, 1'b0);
            t0 = now - 3;
            wait_end();
            check_dt(tm, "range delay length");
            check(blink, tm > 250, "indicator blink");
        end
        for (int j = 0; j < 3; j++) begin
            setup(1'b0, 1'b0, 2'h0, lr[j], lf[j]);
            drive(1'b1, 1'b0);
            repeat (200) @(negedge clk_sys);
            check(timing_q & ~relay_out_q, 1'b1, "long range ended");
        end
        $display("test ranges done");
    endtask : t_ranges

    initial begin
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        t_on_delay();
        t_interval();
        t_off_delay();
        t_one_shot();
        t_on_off();
        t_latch();
        t_ranges();
        summarize();
    end
endmodule : drt_ctrl_test
`default_nettype wire
